// ### pkg/ccw_consts.svh
`ifndef CCW_CONSTS_SVH
`define CCW_CONSTS_SVH

// Register byte addresses.
`define CCW_ADDR_CONFIG 32'hfff02000
`define CCW_ADDR_COMMAND 32'hfff02004
`define CCW_ADDR_LINE 32'hfff02008
`define CCW_ADDR_TEST_CTL 32'hfff60000
`define CCW_ADDR_TEST_RES 32'hfff60004

// Configuration fields.
`define CCW_CFG_ICACHE 0
`define CCW_CFG_DCACHE 1
`define CCW_CFG_WBUF 2
`define CCW_CFG_MASK 32'h00000007

// Command fields.
`define CCW_CMD_ISEL 0
`define CCW_CMD_DSEL 1
`define CCW_CMD_INV_ALL 2
`define CCW_CMD_INV_ONE 3
`define CCW_CMD_FETCH_PIN 4
`define CCW_CMD_UNLOCK_ALL 5
`define CCW_CMD_UNLOCK_ONE 6
`define CCW_CMD_DRAIN 7
`define CCW_CMD_MASK 32'h000000ff

// Line address fields.
`define CCW_LINE_WAY 31
`define CCW_LINE_SET_LO 4
`define CCW_LINE_TAG_LO 11
`define CCW_LINE_TAG_HI 30

// Self-test fields.
`define CCW_TST_GO 15
`define CCW_TST_GRP_LO 8
`define CCW_TST_CTL_MASK 32'h00008f00
`define CCW_TST_DONE 31

// Reset values and sizes.
`define CCW_RESET_WORD 32'h00000000
`define CCW_WBUF_DEPTH 8
`define CCW_CACHE_SETS 128
`define CCW_LINE_BYTES 16
`define CCW_BIST_STEPS 256

`endif

// ### pkg/ccw_pkg.sv
package ccw_pkg;
    // Command engine states.
    typedef enum logic [2:0] {
        CCW_IDLE,
        CCW_WALK,
        CCW_FETCH,
        CCW_DRAIN,
        CCW_DONE
    } ccw_state_e;
    // Kind of a line command sent to the cache datapath.
    typedef enum logic [1:0] {
        CCW_OP_INV,
        CCW_OP_UNLOCK,
        CCW_OP_PIN
    } ccw_op_e;
    typedef logic [31:0] ccw_word_t;
endpackage

// ### src/ccw_wbuf.sv
`timescale 1ns/1ps
`include "ccw_consts.svh"

// Write buffer: holds posted stores until external memory takes them.
module ccw_wbuf #(
    parameter int DEPTH = `CCW_WBUF_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_wr_valid,
    input wire ccw_pkg::ccw_word_t i_wr_data,
    input wire ccw_pkg::ccw_word_t i_wr_addr,
    output logic o_wr_ready,
    output logic o_mem_valid,
    output ccw_pkg::ccw_word_t o_mem_data,
    output ccw_pkg::ccw_word_t o_mem_addr,
    input wire logic i_mem_ready,
    output logic o_empty
);
    import ccw_pkg::*;
    localparam int AW = $clog2(DEPTH);

    // Refuse a depth that the wrapping pointers cannot serve.
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("ccw_wbuf: DEPTH must be a power of two of at least two");
    end

    ccw_word_t data_mem [DEPTH];
    ccw_word_t addr_mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign o_empty = (wr_ptr_r == rd_ptr_r);
    assign o_wr_ready = i_enable && !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
    assign push = i_wr_valid && o_wr_ready;
    assign o_mem_valid = !o_empty;
    assign pop = o_mem_valid && i_mem_ready;
    assign o_mem_data = data_mem[rd_ptr_r[AW-1:0]];
    assign o_mem_addr = addr_mem[rd_ptr_r[AW-1:0]];

    // Storage array written on an accepted store.
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            data_mem[wr_ptr_r[AW-1:0]] <= i_wr_data;
            addr_mem[wr_ptr_r[AW-1:0]] <= i_wr_addr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // Occupancy never passes the depth.
    AST_WBUF_BOUND: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_ptr_r - rd_ptr_r) <= (AW+1)'(DEPTH))
        else $error("write buffer over depth");
endmodule

// ### src/ccw_bist.sv
`timescale 1ns/1ps
`include "ccw_consts.svh"

// Self-test sequencer: walks every address of the picked groups.
module ccw_bist #(
    parameter int STEPS = `CCW_BIST_STEPS
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic [3:0] i_groups,
    input wire logic [7:0] i_ram_fault,
    output logic o_running,
    output logic o_done,
    output logic [7:0] o_fault
);
    import ccw_pkg::*;
    localparam int CW = $clog2(STEPS);

    // Refuse a run too short for the step counter.
    if (STEPS < 2)
    begin
        $error("ccw_bist: STEPS must be at least two");
    end

    logic [CW-1:0] step_r;
    logic [7:0] pick;
    logic start_prev_r;

    // Go level of the last cycle; a run starts only when go is raised, so the
    // finish flag stays set while software leaves go at one.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            start_prev_r <= 1'b0;
        else
            start_prev_r <= i_start;
    end

    // Map groups to per-way fault bits: tags high nibble, data low nibble.
    assign pick = {{2{i_groups[3]}}, {2{i_groups[2]}}, {2{i_groups[1]}}, {2{i_groups[0]}}};

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            step_r <= '0;
            o_running <= 1'b0;
            o_done <= 1'b0;
            o_fault <= 8'h00;
        end
        else if (i_start && !start_prev_r && !o_running)
        begin
            step_r <= '0;
            o_running <= 1'b1;
            o_done <= 1'b0;
            o_fault <= 8'h00;
        end
        else if (o_running)
        begin
            o_fault <= o_fault | (i_ram_fault & pick);
            step_r <= step_r + 1'b1;
            if (step_r == CW'(STEPS - 1))
            begin
                o_running <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end

    AST_BIST_DONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $fell(o_running) |-> o_done)
        else $error("self test ended without done");
endmodule

// ### src/ccw_ctrl.sv
// Function
// - write buffer holds up to eight words
// - config bit 2 enables buffer, reset empties
// - drain with data select empties buffer
// - config bits enable caches, reset off
// - command bits clear after the operation
// - bit 6 unlocks addressed line
// - bit 5 unlocks every line
// - bit 4 fetches and pins a line
// - bit 3 invalidates addressed line
// - bit 2 invalidates all lines, pins too
// - bits 1 and 0 select data, instruction
// - all-line commands may hit both caches
// - single-line with both selects is ignored
// - drain with instruction select is ignored
// - line address holds way and address
// - test bit 15 starts self-test
// - test bits 11..8 pick memory groups
// - any group mix tested together
// - finish bit set when test ends
// - fault bits per RAM and way
// - 128 sets, 16-byte lines
// - pinned lines survive single-line invalidate
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "ccw_consts.svh"

module ccw_ctrl #(
    parameter int SETS = `CCW_CACHE_SETS,
    parameter int WBUF_DEPTH = `CCW_WBUF_DEPTH,
    parameter int BIST_STEPS = `CCW_BIST_STEPS
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [31:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire ccw_pkg::ccw_word_t i_wb_dat,
    output ccw_pkg::ccw_word_t o_wb_dat,
    output logic o_wb_ack,
    output logic o_wb_err,
    output logic o_iside_cache_on,
    output logic o_dside_cache_on,
    output logic o_wbuf_on,
    output logic o_line_cmd_valid,
    output ccw_pkg::ccw_op_e o_line_cmd_op,
    output logic o_line_cmd_dside,
    output logic o_line_cmd_way,
    output logic [$clog2(`CCW_CACHE_SETS)-1:0] o_line_cmd_set,
    output logic [19:0] o_line_cmd_tag,
    output logic o_line_cmd_all,
    input wire logic i_line_cmd_done,
    input wire logic i_st_valid,
    input wire ccw_pkg::ccw_word_t i_st_data,
    input wire ccw_pkg::ccw_word_t i_st_addr,
    output logic o_st_ready,
    output logic o_mem_valid,
    output ccw_pkg::ccw_word_t o_mem_data,
    output ccw_pkg::ccw_word_t o_mem_addr,
    input wire logic i_mem_ready,
    input wire logic [7:0] i_ram_fault,
    output logic o_bist_running
);
    import ccw_pkg::*;
    localparam int SW = $clog2(SETS);

    // Refuse a set count that the fixed set field cannot address.
    if (SETS != `CCW_CACHE_SETS)
    begin
        $error("ccw_ctrl: SETS must match the set field of the line address");
    end

    // Byte lane merge for a register write.
    function automatic ccw_word_t merge(input ccw_word_t old, input ccw_word_t nw,
                                        input logic [3:0] sel, input ccw_word_t mask);
        ccw_word_t res;
        for (int b = 0; b < 4; b++)
            res[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        return res & mask;
    endfunction

    ccw_word_t config_r;
    ccw_word_t line_r;
    logic [7:0] cmd_r;
    logic [15:0] test_ctl_r;
    ccw_state_e state_r;
    logic phase_r;
    logic [1:0] caches_r;
    logic ack_r;
    logic err_r;
    ccw_word_t rdata_r;
    logic req;
    logic hit_cfg;
    logic hit_cmd;
    logic hit_line;
    logic hit_tctl;
    logic hit_tres;
    logic mapped;
    logic cmd_wr;
    ccw_word_t cmd_new;
    logic wbuf_empty;
    logic bist_start;
    logic bist_done;
    logic [7:0] bist_fault;

    // Address decode of a new bus request.
    assign req = i_wb_cyc && i_wb_stb && !ack_r && !err_r;
    assign hit_cfg = (i_wb_adr == `CCW_ADDR_CONFIG);
    assign hit_cmd = (i_wb_adr == `CCW_ADDR_COMMAND);
    assign hit_line = (i_wb_adr == `CCW_ADDR_LINE);
    assign hit_tctl = (i_wb_adr == `CCW_ADDR_TEST_CTL);
    assign hit_tres = (i_wb_adr == `CCW_ADDR_TEST_RES);
    assign mapped = hit_cfg || hit_cmd || hit_line || hit_tctl || hit_tres;
    assign cmd_wr = req && i_wb_we && hit_cmd && state_r == CCW_IDLE;
    assign cmd_new = merge({24'h000000, cmd_r}, i_wb_dat, i_wb_sel, `CCW_CMD_MASK);

    // Single-cycle ack; unmapped addresses answer with err.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end
        else
        begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
        end
    end
    assign o_wb_ack = ack_r;
    assign o_wb_err = err_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_r <= `CCW_RESET_WORD;
        else if (req && !i_wb_we)
        begin
            unique case (1'b1)
                hit_cfg: rdata_r <= config_r;
                hit_cmd: rdata_r <= {24'h000000, cmd_r};
                hit_line: rdata_r <= line_r;
                hit_tctl: rdata_r <= {16'h0000, test_ctl_r};
                hit_tres: rdata_r <= {bist_done, 23'h000000, bist_done ? bist_fault : 8'h00};
                default: rdata_r <= `CCW_RESET_WORD;
            endcase
        end
    end
    assign o_wb_dat = rdata_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            config_r <= `CCW_RESET_WORD;
        else if (req && i_wb_we && hit_cfg)
            config_r <= merge(config_r, i_wb_dat, i_wb_sel, `CCW_CFG_MASK);
    end
    assign o_iside_cache_on = config_r[`CCW_CFG_ICACHE];
    assign o_dside_cache_on = config_r[`CCW_CFG_DCACHE];
    assign o_wbuf_on = config_r[`CCW_CFG_WBUF];

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            line_r <= `CCW_RESET_WORD;
        else if (req && i_wb_we && hit_line)
            line_r <= merge(line_r, i_wb_dat, i_wb_sel, 32'hffffffff);
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            test_ctl_r <= 16'h0000;
        else if (req && i_wb_we && hit_tctl)
            test_ctl_r <= 16'(merge({16'h0000, test_ctl_r}, i_wb_dat, i_wb_sel,
                                    `CCW_TST_CTL_MASK));
    end
    assign bist_start = test_ctl_r[`CCW_TST_GO];

    // Command engine: one command runs at a time; the register clears at the end.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= CCW_IDLE;
            cmd_r <= 8'h00;
            phase_r <= 1'b0;
            caches_r <= 2'b00;
        end
        else
        begin
            unique case (state_r)
                CCW_IDLE:
                begin
                    if (cmd_wr)
                    begin
                        cmd_r <= cmd_new[7:0];
                        caches_r <= cmd_new[1:0];
                        phase_r <= 1'b0;
                        if (cmd_new[1:0] == 2'b00 || cmd_new[7:2] == 6'h00)
                            state_r <= CCW_DONE;
                        else if (cmd_new[`CCW_CMD_DRAIN])
                            state_r <= (cmd_new[1:0] == 2'b10) ? CCW_DRAIN : CCW_DONE;
                        else if ((cmd_new[`CCW_CMD_INV_ONE] || cmd_new[`CCW_CMD_UNLOCK_ONE])
                                 && cmd_new[1:0] == 2'b11)
                            state_r <= CCW_DONE;
                        else if (cmd_new[`CCW_CMD_FETCH_PIN])
                            state_r <= (cmd_new[1:0] == 2'b11) ? CCW_DONE : CCW_FETCH;
                        else
                            state_r <= CCW_WALK;
                    end
                end
                CCW_WALK:
                begin
                    if (i_line_cmd_done)
                    begin
                        if (!phase_r && caches_r == 2'b11)
                            phase_r <= 1'b1;
                        else
                            state_r <= CCW_DONE;
                    end
                end
                CCW_FETCH:
                begin
                    if (i_line_cmd_done)
                        state_r <= CCW_DONE;
                end
                CCW_DRAIN:
                begin
                    if (wbuf_empty)
                        state_r <= CCW_DONE;
                end
                CCW_DONE:
                begin
                    cmd_r <= 8'h00;
                    state_r <= CCW_IDLE;
                end
            endcase
        end
    end

    // Line command to the cache datapath.
    // valid while walking or fetching; cache select follows
    assign o_line_cmd_valid = (state_r == CCW_WALK) || (state_r == CCW_FETCH);
    assign o_line_cmd_dside = (caches_r == 2'b11) ? phase_r : caches_r[1];
    assign o_line_cmd_all = cmd_r[`CCW_CMD_INV_ALL] || cmd_r[`CCW_CMD_UNLOCK_ALL];
    assign o_line_cmd_op = (cmd_r[`CCW_CMD_FETCH_PIN]) ? CCW_OP_PIN :
                           (cmd_r[`CCW_CMD_UNLOCK_ALL] || cmd_r[`CCW_CMD_UNLOCK_ONE]) ?
                           CCW_OP_UNLOCK : CCW_OP_INV;
    assign o_line_cmd_way = line_r[`CCW_LINE_WAY];
    assign o_line_cmd_set = line_r[`CCW_LINE_SET_LO +: SW];
    assign o_line_cmd_tag = line_r[`CCW_LINE_TAG_HI:`CCW_LINE_TAG_LO];

    ccw_wbuf #(
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_enable(o_wbuf_on),
        .i_wr_valid(i_st_valid),
        .i_wr_data(i_st_data),
        .i_wr_addr(i_st_addr),
        .o_wr_ready(o_st_ready),
        .o_mem_valid(o_mem_valid),
        .o_mem_data(o_mem_data),
        .o_mem_addr(o_mem_addr),
        .i_mem_ready(i_mem_ready),
        .o_empty(wbuf_empty)
    );

    ccw_bist #(
        .STEPS(BIST_STEPS)
    ) u_bist (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_start(bist_start),
        .i_groups(test_ctl_r[`CCW_TST_GRP_LO +: 4]),
        .i_ram_fault(i_ram_fault),
        .o_running(o_bist_running),
        .o_done(bist_done),
        .o_fault(bist_fault)
    );

    AST_CMD_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_r == CCW_DONE |=> cmd_r == 8'h00 && state_r == CCW_IDLE)
        else $error("command bits did not clear");
    AST_DRAIN_EMPTY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_r == CCW_DRAIN && wbuf_empty |=> state_r == CCW_DONE)
        else $error("drain did not finish on empty");
    AST_DRAIN_ISEL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_r == CCW_DRAIN |-> caches_r == 2'b10)
        else $error("drain ran with instruction select");
    AST_ONE_BOTH: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_line_cmd_valid && !o_line_cmd_all |-> caches_r != 2'b11)
        else $error("single line command on both caches");
    AST_NO_SEL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        cmd_wr && cmd_new[1:0] == 2'b00 |=> state_r == CCW_DONE ##1 cmd_r == 8'h00)
        else $error("unselected command not dropped");
    AST_BOTH_WALK: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_r == CCW_WALK && caches_r == 2'b11 && !phase_r && i_line_cmd_done
        |=> state_r == CCW_WALK && o_line_cmd_dside)
        else $error("second cache not walked");
    AST_WBUF_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !o_wbuf_on |-> !o_st_ready)
        else $error("buffer accepted while off");
    AST_ACK_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    AST_CFG_RESV: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        config_r[31:3] == 29'h0)
        else $error("reserved config bits set");
endmodule

// ### bench/ccw_far_model.sv
`timescale 1ns/1ps

// Stand-in for the cache datapath and external memory facing the block.
module ccw_far_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_line_cmd_valid,
    input wire logic i_stall,
    output logic o_line_cmd_done,
    output logic o_mem_ready
);
    logic [2:0] wait_r;
    logic [1:0] phase_r;

    // One done pulse per command after a random delay; a gap cycle stops a stale valid rearming.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wait_r <= 3'h0;
            phase_r <= 2'h0;
            o_line_cmd_done <= 1'b0;
        end
        else
        begin
            o_line_cmd_done <= 1'b0;
            if (phase_r == 2'h0 && i_line_cmd_valid)
            begin
                phase_r <= 2'h1;
                wait_r <= 3'($urandom % 5);
            end
            else if (phase_r == 2'h1 && wait_r != 3'h0)
                wait_r <= wait_r - 3'h1;
            else if (phase_r == 2'h1)
            begin
                phase_r <= 2'h2;
                o_line_cmd_done <= 1'b1;
            end
            else
                phase_r <= 2'h0;
        end
    end

    // Memory takes a word about half the time unless the bench holds it off.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_mem_ready <= 1'b0;
        else
            o_mem_ready <= !i_stall && ($urandom % 2 == 1);
    end
endmodule

// ### bench/test_cache_ctrl_wbuf_bist.sv
`timescale 1ns/1ps
`include "ccw_consts.svh"

module test_cache_ctrl_wbuf_bist;
    import ccw_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, st_valid = 0, stall = 0;
    logic [31:0] adr = 0, wdat = 0, st_data = 0, st_addr = 0, rd, cexp, cmask;
    logic [7:0] fault = 0;
    logic [3:0] sel = 4'hf, lanes = 4'hf;
    logic [33:0] note;
    logic [63:0] mexp;
    ccw_word_t rdat, mem_data, mem_addr;
    logic ack, err, ion, don, wbon, lv, lds, lway, lall, done, st_ready, mem_valid, mem_ready;
    logic running;
    ccw_op_e lop;
    logic [6:0] lset;
    logic [19:0] ltag;
    int miscompares = 0, comparisons = 0;
    logic [33:0] rd_q[$];
    logic [31:0] cmd_q[$];
    logic [63:0] mem_q[$];
    int cmd_bits[5] = '{2, 3, 4, 5, 6};
    ccw_op_e ops[5] = '{CCW_OP_INV, CCW_OP_INV, CCW_OP_PIN, CCW_OP_UNLOCK, CCW_OP_UNLOCK};
    logic [31:0] regs[5] = '{`CCW_ADDR_CONFIG, `CCW_ADDR_COMMAND, `CCW_ADDR_LINE,
        `CCW_ADDR_TEST_CTL, `CCW_ADDR_TEST_RES};

    // Free-running system clock.
    initial forever #5 clk = ~clk;

    ccw_ctrl #(.BIST_STEPS(4)) dut (
        .i_sys_clk(clk),
        .i_reset_n(rst_n),
        .i_wb_cyc(cyc),
        .i_wb_stb(stb),
        .i_wb_we(we),
        .i_wb_adr(adr),
        .i_wb_sel(sel),
        .i_wb_dat(wdat),
        .o_wb_dat(rdat),
        .o_wb_ack(ack),
        .o_wb_err(err),
        .o_iside_cache_on(ion),
        .o_dside_cache_on(don),
        .o_wbuf_on(wbon),
        .o_line_cmd_valid(lv),
        .o_line_cmd_op(lop),
        .o_line_cmd_dside(lds),
        .o_line_cmd_way(lway),
        .o_line_cmd_set(lset),
        .o_line_cmd_tag(ltag),
        .o_line_cmd_all(lall),
        .i_line_cmd_done(done),
        .i_st_valid(st_valid),
        .i_st_data(st_data),
        .i_st_addr(st_addr),
        .o_st_ready(st_ready),
        .o_mem_valid(mem_valid),
        .o_mem_data(mem_data),
        .o_mem_addr(mem_addr),
        .i_mem_ready(mem_ready),
        .i_ram_fault(fault),
        .o_bist_running(running)
    );

    ccw_far_model far (
        .i_sys_clk(clk),
        .i_reset_n(rst_n),
        .i_line_cmd_valid(lv),
        .i_stall(stall),
        .o_line_cmd_done(done),
        .o_mem_ready(mem_ready)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One classic bus cycle; a read leaves its expectation for the monitor.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [33:0] exp);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        if (!w)
            rd_q.push_back(exp);
        do
            @(posedge clk);
        while (!(ack || err));
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 34'h0);
    endtask

    task automatic rdx(input logic [31:0] a, input logic [31:0] d);
        bus(1'b0, a, 32'h0, {2'b00, d});
    endtask

    // Reads until the register shows the wanted value, under a bounded count.
    task automatic poll(input logic [31:0] a, input logic [31:0] want);
        for (int i = 0; i < 60; i++)
        begin
            bus(1'b0, a, 32'h0, {1'b1, 33'h0});
            if (rd === want)
                break;
        end
        check(rd, want);
    endtask

    // Offers stores for a fixed span and counts those the buffer takes.
    task automatic fill(output int n);
        n = 0;
        st_addr <= $urandom;
        st_data <= $urandom;
        st_valid <= 1'b1;
        repeat (14)
        begin
            @(posedge clk);
            if (st_ready)
            begin
                n++;
                mem_q.push_back({st_addr, st_data});
                st_addr <= $urandom;
                st_data <= $urandom;
            end
        end
        st_valid <= 1'b0;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        mem_q.delete();
    endtask

    function automatic logic [31:0] line_exp(input ccw_op_e op, input logic ds,
        input logic [31:0] a, input logic all);
        return {op, ds, a[31], a[10:4], a[30:11], all};
    endfunction

    // Takes the oldest note for each read answer, finished line command and memory write.
    always @(posedge clk)
    begin
        if ((ack || err) && !we && rd_q.size() > 0)
        begin
            note = rd_q.pop_front();
            if (!note[33])
                check({err, note[32] ? 32'h0 : rdat}, note[32:0]);
        end
        if (done)
        begin
            cexp = cmd_q.size() > 0 ? cmd_q.pop_front() : 32'hffffffff;
            cmask = cexp[0] ? 32'he0000001 : 32'hffffffff;
            check({lop, lds, lway, lset, ltag, lall} & cmask, cexp & cmask);
        end
        if (mem_valid && mem_ready)
        begin
            mexp = mem_q.size() > 0 ? mem_q.pop_front() : 64'hffffffffffffffff;
            check({mem_addr, mem_data}, mexp);
        end
    end

    // Cuts a hang short; the tests need far less than this.
    initial
    begin
        #300us;
        miscompares++;
        conclude();
    end

    initial
    begin
        logic [31:0] a, v, base;
        int n;
        logic [3:0] grp;
        logic all;
        void'($urandom(32'h367434ac));
        do_reset();
        wr(`CCW_ADDR_TEST_RES, 32'hffffffff);
        foreach (regs[i])
            rdx(regs[i], 32'h0);
        check({ion, don, wbon}, 3'h0);
        bus(1'b0, 32'hfff02010, 32'h0, {2'b01, 32'h0});
        wr(`CCW_ADDR_COMMAND, 32'hffffff00);
        rdx(`CCW_ADDR_COMMAND, 32'h0);
        repeat (4)
        begin
            v = $urandom;
            wr(`CCW_ADDR_CONFIG, v);
            rdx(`CCW_ADDR_CONFIG, v & `CCW_CFG_MASK);
            check({wbon, don, ion}, v[2:0]);
            wr(`CCW_ADDR_LINE, v);
            rdx(`CCW_ADDR_LINE, v);
        end
        // Byte lanes: only the picked lanes of a write land.
        lanes = 4'h5;
        wr(`CCW_ADDR_LINE, ~v);
        lanes = 4'hf;
        rdx(`CCW_ADDR_LINE, {v[31:24], ~v[23:16], v[15:8], ~v[7:0]});
        base = $urandom & 32'hfffffff0;
        foreach (cmd_bits[b])
            for (int s = 0; s < 4; s++)
            begin
                a = base + 32'(16 * (b * 4 + s));
                wr(`CCW_ADDR_LINE, a);
                all = cmd_bits[b] == 2 || cmd_bits[b] == 5;
                if (s == 1 || (s == 3 && all))
                    cmd_q.push_back(line_exp(ops[b], 1'b0, a, all));
                if (s == 2 || (s == 3 && all))
                    cmd_q.push_back(line_exp(ops[b], 1'b1, a, all));
                wr(`CCW_ADDR_COMMAND, (32'h1 << cmd_bits[b]) | 32'(s));
                poll(`CCW_ADDR_COMMAND, 32'h0);
            end
        stall <= 1'b1;
        wr(`CCW_ADDR_CONFIG, 32'h0);
        fill(n);
        check(n, 0);
        wr(`CCW_ADDR_CONFIG, 32'h4);
        fill(n);
        check(n, `CCW_WBUF_DEPTH);
        wr(`CCW_ADDR_COMMAND, 32'h83);
        poll(`CCW_ADDR_COMMAND, 32'h0);
        wr(`CCW_ADDR_COMMAND, 32'h82);
        rdx(`CCW_ADDR_COMMAND, 32'h82);
        stall <= 1'b0;
        poll(`CCW_ADDR_COMMAND, 32'h0);
        check(mem_q.size(), 0);
        stall <= 1'b1;
        fill(n);
        do_reset();
        @(posedge clk);
        check({mem_valid, st_ready}, 2'h0);
        stall <= 1'b0;
        for (int g = 0; g < 5; g++)
        begin
            grp = g < 4 ? 4'(1 << g) : 4'hf;
            fault <= 8'($urandom);
            wr(`CCW_ADDR_TEST_CTL, 32'h8000 | {20'h0, grp, 8'h0});
            do
                @(posedge clk);
            while (!running);
            do
                @(posedge clk);
            while (running);
            wr(`CCW_ADDR_TEST_CTL, {20'h0, grp, 8'h0});
            rdx(`CCW_ADDR_TEST_CTL, {20'h0, grp, 8'h0});
            v = {24'h800000, fault & {{2{grp[3]}}, {2{grp[2]}}, {2{grp[1]}}, {2{grp[0]}}}};
            rdx(`CCW_ADDR_TEST_RES, v);
        end
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
